// file: rtl/spd_post_div.sv
// Purpose: Output stage of post-dividers B and C: divided clock, low-frequency clock, frame pulse
// Assumes: All inputs synchronous to clk_in; sibling clocks are slower than clk_in / 2
// Notes: Outputs are registered waveforms built from clk_in edges

module spd_post_div (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Timing sources
  input wire logic base_x2_tick_in,
  input wire logic sib_a_clk_in,
  input wire logic sib_d_clk_in,
  // Outputs
  output logic div_b_out,
  output logic div_c_out
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Kind decode
  function automatic spd_pkg::spd_mode_t mode_of(input logic [23:0] r, input logic [1:0] lf_sel);
    if (r[spd_pkg::SPD_KIND_MSB:spd_pkg::SPD_KIND_LSB] != spd_pkg::SPD_KIND_SPECIAL) begin
      return spd_pkg::SPD_MODE_DIV;
    end else if (r[spd_pkg::SPD_SEL_MSB:spd_pkg::SPD_SEL_LSB] == lf_sel) begin
      return spd_pkg::SPD_MODE_LF;
    end
    return spd_pkg::SPD_MODE_FRAME;
  endfunction

  // Divisors below two cannot form a toggling clock from clk_in flops
  function automatic logic [23:0] clamp_div(input logic [23:0] n);
    return (n < spd_pkg::SPD_DIV_MIN) ? spd_pkg::SPD_DIV_MIN : n;
  endfunction

  // Odd divisors stay high one extra cycle: (n+1)/2 of n
  function automatic logic [23:0] high_len(input logic [23:0] n);
    logic [24:0] s;
    s = {1'b0, n} + 25'h000_0001;
    return s[24:1];
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [23:0] div_reg_q [2];
  logic [7:0] rdata_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div_reg_q[0] <= spd_pkg::SPD_B_RESET;
      div_reg_q[1] <= spd_pkg::SPD_C_RESET;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        spd_pkg::SPD_B_HI_ADDR: div_reg_q[0][23:16] <= reg_wdata_in;
        spd_pkg::SPD_B_MD_ADDR: div_reg_q[0][15:8] <= reg_wdata_in;
        spd_pkg::SPD_B_LO_ADDR: div_reg_q[0][7:0] <= reg_wdata_in;
        spd_pkg::SPD_C_HI_ADDR: div_reg_q[1][23:16] <= reg_wdata_in;
        spd_pkg::SPD_C_MD_ADDR: div_reg_q[1][15:8] <= reg_wdata_in;
        spd_pkg::SPD_C_LO_ADDR: div_reg_q[1][7:0] <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= 8'h00;
    end else begin
      case (reg_addr_in)
        spd_pkg::SPD_B_HI_ADDR: rdata_q <= div_reg_q[0][23:16];
        spd_pkg::SPD_B_MD_ADDR: rdata_q <= div_reg_q[0][15:8];
        spd_pkg::SPD_B_LO_ADDR: rdata_q <= div_reg_q[0][7:0];
        spd_pkg::SPD_C_HI_ADDR: rdata_q <= div_reg_q[1][23:16];
        spd_pkg::SPD_C_MD_ADDR: rdata_q <= div_reg_q[1][15:8];
        spd_pkg::SPD_C_LO_ADDR: rdata_q <= div_reg_q[1][7:0];
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign reg_rdata_out = rdata_q;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  spd_pkg::spd_mode_t mode [2];
  logic [23:0] eff_div [2];
  logic [23:0] half_div [2];
  logic [1:0] sel [2];
  logic pol [2];
  logic gci [2];
  logic [15:0] fr_last [2];
  logic out_q [2];
  logic sib_lvl [2];

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      sel[i] = div_reg_q[i][spd_pkg::SPD_SEL_MSB:spd_pkg::SPD_SEL_LSB];
      pol[i] = div_reg_q[i][spd_pkg::SPD_POL_BIT];
      gci[i] = div_reg_q[i][spd_pkg::SPD_TYPE_BIT];
      // Zero spacing is treated as one period
      fr_last[i] = (div_reg_q[i][spd_pkg::SPD_RATE_MSB:0] < spd_pkg::SPD_RATE_MIN) ? 16'h0000 :
                   16'(div_reg_q[i][spd_pkg::SPD_RATE_MSB:0] - spd_pkg::SPD_RATE_MIN);
    end
    mode[0] = mode_of(div_reg_q[0], spd_pkg::SPD_SEL_LF_B);
    mode[1] = mode_of(div_reg_q[1], spd_pkg::SPD_SEL_LF_C);
    for (int i = 0; i < 2; i++) begin
      // Full 24-bit divisor outside kind 1111, 16-bit factor in low-frequency mode
      if (mode[i] == spd_pkg::SPD_MODE_LF) begin
        eff_div[i] = clamp_div({8'h00, div_reg_q[i][spd_pkg::SPD_RATE_MSB:0]});
      end else begin
        eff_div[i] = clamp_div(div_reg_q[i]);
      end
      half_div[i] = high_len(eff_div[i]);
    end
    case (sel[0])
      spd_pkg::SPD_SEL_A: sib_lvl[0] = sib_a_clk_in;
      spd_pkg::SPD_SEL_D: sib_lvl[0] = sib_d_clk_in;
      spd_pkg::SPD_SEL_LF_C: sib_lvl[0] = out_q[1];
      default: sib_lvl[0] = 1'b0;
    endcase
    case (sel[1])
      spd_pkg::SPD_SEL_A: sib_lvl[1] = sib_a_clk_in;
      spd_pkg::SPD_SEL_D: sib_lvl[1] = sib_d_clk_in;
      spd_pkg::SPD_SEL_LF_B: sib_lvl[1] = out_q[0];
      default: sib_lvl[1] = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Divided and low-frequency clock
  // ---------------------------------------------------------------
  logic [23:0] div_cnt_q [2];
  logic [23:0] div_cnt_d [2];
  logic wave_q [2];

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      div_cnt_d[i] = div_cnt_q[i];
      // Free-running count on clk_in in divide mode; on base ticks only in low-frequency mode; held in frame mode
      if (mode[i] == spd_pkg::SPD_MODE_DIV ||
          (mode[i] == spd_pkg::SPD_MODE_LF && base_x2_tick_in)) begin
        div_cnt_d[i] = (div_cnt_q[i] >= eff_div[i] - 24'h00_0001) ? 24'h00_0000 :
                       24'(div_cnt_q[i] + 24'h00_0001);
      end
    end
  end

  // Duty depends on clk_in granularity; an even divisor gives exact 50%
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_in) begin
        div_cnt_q[i] <= 24'h00_0000;
        wave_q[i] <= 1'b0;
      end else begin
        div_cnt_q[i] <= div_cnt_d[i];
        wave_q[i] <= (div_cnt_d[i] < half_div[i]);
      end
    end
  end

  // ---------------------------------------------------------------
  // Frame pulse
  // ---------------------------------------------------------------
  logic sib_prev_q [2];
  logic [15:0] fr_cnt_q [2];
  spd_pkg::spd_fp_state_t fp_q [2];
  logic rise [2];
  logic trig [2];
  logic start [2];

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      rise[i] = sib_lvl[i] & ~sib_prev_q[i];
      // Leading-edge style works on rising edges, mid-pulse style a half period early
      trig[i] = gci[i] ? rise[i] : (~sib_lvl[i] & sib_prev_q[i]);
      start[i] = trig[i] && (fr_cnt_q[i] == fr_last[i]);
    end
  end

  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_in) begin
        sib_prev_q[i] <= 1'b0;
        fr_cnt_q[i] <= 16'h0000;
      end else begin
        sib_prev_q[i] <= sib_lvl[i];
        if (mode[i] != spd_pkg::SPD_MODE_FRAME) begin
          fr_cnt_q[i] <= 16'h0000;
        end else if (rise[i]) begin
          fr_cnt_q[i] <= (fr_cnt_q[i] >= fr_last[i]) ? 16'h0000 : 16'(fr_cnt_q[i] + 16'h0001);
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_in || mode[i] != spd_pkg::SPD_MODE_FRAME) begin
        fp_q[i] <= spd_pkg::SPD_FP_IDLE;
      end else begin
        // Pulse opens and closes only on sibling edges
        case (fp_q[i])
          spd_pkg::SPD_FP_IDLE: begin
            if (start[i]) begin
              fp_q[i] <= spd_pkg::SPD_FP_ACTIVE;
            end
          end
          spd_pkg::SPD_FP_ACTIVE: begin
            if (trig[i] && !start[i]) begin
              fp_q[i] <= spd_pkg::SPD_FP_IDLE;
            end
          end
          default: fp_q[i] <= spd_pkg::SPD_FP_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Output select
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_in) begin
        out_q[i] <= 1'b0;
      end else if (mode[i] == spd_pkg::SPD_MODE_FRAME) begin
        out_q[i] <= (fp_q[i] == spd_pkg::SPD_FP_ACTIVE) ^ pol[i];
      end else begin
        out_q[i] <= wave_q[i];
      end
    end
  end

  assign div_b_out = out_q[0];
  assign div_c_out = out_q[1];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // Counter and wave still hold reset values on the first edge after release
  a_div_starts_high: assert property (@(posedge clk_in) disable iff (rst_in)
    (!$past(rst_in) && mode[0] == spd_pkg::SPD_MODE_DIV &&
     $past(mode[0]) == spd_pkg::SPD_MODE_DIV && div_cnt_q[0] == 24'h00_0000) |-> wave_q[0])
    else $error("divided clock not high at count start");

  a_div_wrap_c: assert property (@(posedge clk_in) disable iff (rst_in)
    (mode[1] == spd_pkg::SPD_MODE_DIV && div_cnt_q[1] >= eff_div[1] - 24'h00_0001 &&
     $stable(div_reg_q[1])) |=> div_cnt_q[1] == 24'h00_0000)
    else $error("divider C did not wrap at full divisor");

  a_lf_hold_b: assert property (@(posedge clk_in) disable iff (rst_in)
    (mode[0] == spd_pkg::SPD_MODE_LF && !base_x2_tick_in) |=> $stable(div_cnt_q[0]))
    else $error("low-frequency count on B moved without a base tick");

  a_lf_hold_c: assert property (@(posedge clk_in) disable iff (rst_in)
    (mode[1] == spd_pkg::SPD_MODE_LF && !base_x2_tick_in) |=> $stable(div_cnt_q[1]))
    else $error("low-frequency count on C moved without a base tick");

  a_odd_duty_fall: assert property (@(posedge clk_in) disable iff (rst_in)
    (mode[0] == spd_pkg::SPD_MODE_DIV && $stable(div_reg_q[0]) &&
     $past(div_reg_q[0], 2) == div_reg_q[0] && $fell(wave_q[0]))
    |-> div_cnt_q[0] == half_div[0])
    else $error("divided clock fell at wrong count");

  a_frame_start_c: assert property (@(posedge clk_in) disable iff (rst_in)
    (mode[1] == spd_pkg::SPD_MODE_FRAME && $stable(div_reg_q[1]) && start[1] &&
     fp_q[1] == spd_pkg::SPD_FP_IDLE) ##1 $stable(div_reg_q[1])
    |=> (out_q[1] == !$past(pol[1], 2)))
    else $error("frame pulse C did not open at boundary");

  a_frame_width: assert property (@(posedge clk_in) disable iff (rst_in)
    (mode[0] == spd_pkg::SPD_MODE_FRAME && $stable(div_reg_q[0]) &&
     fp_q[0] == spd_pkg::SPD_FP_ACTIVE && !trig[0]) |=> fp_q[0] == spd_pkg::SPD_FP_ACTIVE)
    else $error("frame pulse B closed off a sibling edge");

  a_frame_space: assert property (@(posedge clk_in) disable iff (rst_in)
    (mode[1] == spd_pkg::SPD_MODE_FRAME && $stable(div_reg_q[1]) && !rise[1])
    |=> $stable(fr_cnt_q[1]))
    else $error("frame spacing count moved without sibling edge");

  a_sel_decode_b: assert property (@(posedge clk_in) disable iff (rst_in)
    sel[0] == spd_pkg::SPD_SEL_LF_C |-> sib_lvl[0] == div_c_out)
    else $error("B selector 10 not routed to C");

  a_sel_decode_c: assert property (@(posedge clk_in) disable iff (rst_in)
    sel[1] == spd_pkg::SPD_SEL_LF_B |-> sib_lvl[1] == div_b_out)
    else $error("C selector 01 not routed to B");

  a_kind_mode: assert property (@(posedge clk_in) disable iff (rst_in)
    (div_reg_q[0][spd_pkg::SPD_KIND_MSB:spd_pkg::SPD_KIND_LSB] != spd_pkg::SPD_KIND_SPECIAL)
    ##1 $stable(div_reg_q[0]) |=> (out_q[0] == $past(wave_q[0])))
    else $error("non-special kind did not select divided clock");

endmodule // spd_post_div

// file: inc/spd_pkg.sv
// Purpose: Constants and types for the synthesizer post-divider output stage
// Assumes: Byte-wide register port, 24-bit divider registers spread over three addresses
// Notes: Channel 0 is post-divider B, channel 1 is post-divider C

package spd_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] SPD_B_HI_ADDR = 8'h83;
  localparam logic [7:0] SPD_B_MD_ADDR = 8'h84;
  localparam logic [7:0] SPD_B_LO_ADDR = 8'h85;
  localparam logic [7:0] SPD_C_HI_ADDR = 8'h86;
  localparam logic [7:0] SPD_C_MD_ADDR = 8'h87;
  localparam logic [7:0] SPD_C_LO_ADDR = 8'h88;
  localparam logic [23:0] SPD_B_RESET = 24'h00_0002;
  localparam logic [23:0] SPD_C_RESET = 24'h00_0040;

  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int SPD_KIND_MSB = 23;
  localparam int SPD_KIND_LSB = 20;
  localparam int SPD_TYPE_BIT = 19;
  localparam int SPD_POL_BIT = 18;
  localparam int SPD_SEL_MSB = 17;
  localparam int SPD_SEL_LSB = 16;
  localparam int SPD_RATE_MSB = 15;
  localparam logic [3:0] SPD_KIND_SPECIAL = 4'hF;
  localparam logic [1:0] SPD_SEL_A = 2'h0;
  localparam logic [1:0] SPD_SEL_LF_B = 2'h1;
  localparam logic [1:0] SPD_SEL_LF_C = 2'h2;
  localparam logic [1:0] SPD_SEL_D = 2'h3;
  localparam logic [23:0] SPD_DIV_MIN = 24'h00_0002;
  localparam logic [15:0] SPD_RATE_MIN = 16'h0001;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SPD_MODE_DIV = 2'b00,
    SPD_MODE_LF = 2'b01,
    SPD_MODE_FRAME = 2'b10
  } spd_mode_t;

  typedef enum logic {
    SPD_FP_IDLE = 1'b0,
    SPD_FP_ACTIVE = 1'b1
  } spd_fp_state_t;

endpackage

// file: sim/tb_spd_post_div.sv
// Purpose: Self-checking bench for the post-divider output stage
// Assumes: Sibling clocks are made here as free-running levels, periods 8 and 10 cycles
// Notes: Each waveform is measured twice and the first period is discarded after a write

module tb_spd_post_div;
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk_in;
  logic rst_in;
  logic [7:0] reg_addr_in;
  logic reg_wr_in;
  logic [7:0] reg_wdata_in;
  wire logic [7:0] reg_rdata_out;
  logic base_x2_tick_in;
  logic sib_a_clk_in;
  logic sib_d_clk_in;
  wire logic div_b_out;
  wire logic div_c_out;
  int error_cnt = 0;
  int checks_done = 0;
  int a_cnt = 0;
  int d_cnt = 0;

  spd_post_div uut (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out),
    .base_x2_tick_in(base_x2_tick_in),
    .sib_a_clk_in(sib_a_clk_in),
    .sib_d_clk_in(sib_d_clk_in),
    .div_b_out(div_b_out),
    .div_c_out(div_c_out)
  );

  // ---------------------------------------------------------------
  // Clock and timing sources
  // ---------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // Sibling half periods of 4 and 5 keep edges well over 2 cycles apart
  always @(posedge clk_in) begin
    base_x2_tick_in <= ~base_x2_tick_in;
    a_cnt <= (a_cnt == 3) ? 0 : a_cnt + 1;
    d_cnt <= (d_cnt == 4) ? 0 : d_cnt + 1;
    if (a_cnt == 3) sib_a_clk_in <= ~sib_a_clk_in;
    if (d_cnt == 4) sib_d_clk_in <= ~sib_d_clk_in;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic step();
    @(posedge clk_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    // Leave the edge time step so callers never sample outputs as they launch
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    reg_addr_in <= a;
    step();
    chk("rdata", {16'h0000, reg_rdata_out}, {16'h0000, exp});
  endtask

  task automatic wr24(input logic [7:0] base, input logic [23:0] v);
    wr(base, v[23:16]);
    wr(base + 8'h01, v[15:8]);
    wr(base + 8'h02, v[7:0]);
  endtask

  function automatic logic act(input bit w, input bit inv);
    return (w ? div_c_out : div_b_out) ^ inv;
  endfunction

  // Active time and rise-to-rise period of one output, in clk_in cycles
  task automatic measure(input bit w, input bit inv, input int src, output int hi,
                         output int per, output logic lvl);
    int n;
    n = 0;
    hi = 0;
    while (act(w, inv) !== 1'b0 && n < 4000) begin step(); n++; end
    while (act(w, inv) !== 1'b1 && n < 4000) begin step(); n++; end
    lvl = (src == 1) ? sib_d_clk_in : sib_a_clk_in;
    while (act(w, inv) === 1'b1 && n < 4000) begin step(); n++; hi++; end
    per = hi;
    while (act(w, inv) === 1'b0 && n < 4000) begin step(); n++; per++; end
    if (n >= 4000) begin
      error_cnt++;
      $display("MISMATCH output_edge expected toggle seen none");
      conclude();
    end
  endtask

  // src 0 samples sibling A, 1 sibling D, 2 skips the phase check
  task automatic run(input string name, input bit w, input logic [23:0] v, input bit inv,
                     input int src, input int ehi, input int eper, input logic elvl);
    int hi;
    int per;
    logic lvl;
    wr24(w ? spd_pkg::SPD_C_HI_ADDR : spd_pkg::SPD_B_HI_ADDR, v);
    measure(w, inv, src, hi, per, lvl);
    measure(w, inv, src, hi, per, lvl);
    chk({name, "_active"}, 24'(hi), 24'(ehi));
    chk({name, "_period"}, 24'(per), 24'(eper));
    if (src < 2) chk({name, "_phase"}, {23'h0, lvl}, {23'h0, elvl});
    $display("test %s done", name);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    reg_addr_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_wdata_in = 8'h00;
    base_x2_tick_in = 1'b0;
    sib_a_clk_in = 1'b0;
    sib_d_clk_in = 1'b0;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    step();
    chk("out_b_reset", {23'h0, div_b_out}, 24'h00_0000);
    chk("out_c_reset", {23'h0, div_c_out}, 24'h00_0000);
    rd(8'h83, 8'h00);
    rd(8'h85, 8'h02);
    rd(8'h87, 8'h00);
    rd(8'h88, 8'h40);
    // Unmapped lane must neither store nor echo
    wr(8'h89, 8'hFF);
    rd(8'h89, 8'h00);
    $display("test registers done");
    run("b_div2", 1'b0, 24'h00_0002, 1'b0, 2, 1, 2, 1'b0);
    run("b_div4", 1'b0, 24'h00_0004, 1'b0, 2, 2, 4, 1'b0);
    run("c_frm_b", 1'b1, 24'hF9_0003, 1'b0, 2, 4, 12, 1'b0);
    rd(8'h86, 8'hF9);
    rd(8'h88, 8'h03);
    run("b_div41", 1'b0, 24'h00_0029, 1'b0, 2, 21, 41, 1'b0);
    run("c_div262", 1'b1, 24'h00_0106, 1'b0, 2, 131, 262, 1'b0);
    run("c_div6", 1'b1, 24'h00_0006, 1'b0, 2, 3, 6, 1'b0);
    run("b_frm_c", 1'b0, 24'hFA_0002, 1'b0, 2, 6, 12, 1'b0);
    run("b_frm_d", 1'b0, 24'hFB_0002, 1'b0, 1, 10, 20, 1'b1);
    run("b_lf4", 1'b0, 24'hF1_0004, 1'b0, 2, 4, 8, 1'b0);
    run("c_lf5", 1'b1, 24'hF2_0005, 1'b0, 2, 6, 10, 1'b0);
    run("c_gci_a", 1'b1, 24'hF8_0003, 1'b0, 0, 8, 24, 1'b1);
    run("c_st_a", 1'b1, 24'hF0_0003, 1'b0, 0, 8, 24, 1'b0);
    run("c_neg_a", 1'b1, 24'hFC_0003, 1'b1, 0, 8, 24, 1'b1);
    run("c_gci_d", 1'b1, 24'hFB_0002, 1'b0, 1, 10, 20, 1'b1);
    run("b_st_neg_a", 1'b0, 24'hF4_0002, 1'b1, 0, 8, 16, 1'b0);
    conclude();
  end
endmodule // tb_spd_post_div
